// [rtl/dps_defs.vh]
// constants for the disk parameter, sleep and dump command block
// assumes byte addresses on the register bus are four times the register index
`ifndef DPS_DEFS_VH
`define DPS_DEFS_VH

// register indices
`define DPS_IX_GATE    6'h21
`define DPS_IX_SCNT    6'h22
`define DPS_IX_SNUM    6'h23
`define DPS_IX_SZLO    6'h24
`define DPS_IX_SZHI    6'h25
`define DPS_IX_DH      6'h26
`define DPS_IX_CMD     6'h27
`define DPS_IX_ISTAT   6'h38
`define DPS_IX_PARAM   6'h3a
`define DPS_IX_CTRL    6'h3b
`define DPS_IX_ALT     6'h3c

// command opcodes in command bits 7:5
`define DPS_OP_SETP    3'h0
`define DPS_OP_LPB     3'h1
`define DPS_OP_SLEEP   3'h2
`define DPS_OP_DUMP    3'h5

// command option bit positions
`define DPS_SP_E       0
`define DPS_SP_H       1
`define DPS_SP_S       2
`define DPS_SP_Z       3
`define DPS_SP_R       4
`define DPS_LP_D       0
`define DPS_LP_K       1
`define DPS_LP_U       2
`define DPS_DM_I       0
`define DPS_DM_B       1
`define DPS_DM_L       2

// status and control bit positions
`define DPS_ISTAT_DONE 3
`define DPS_CTRL_WAKE  7
`define DPS_CTRL_REQEN 0
`define DPS_ERR_DAM    0
`define DPS_ERR_NRDY   1
`define DPS_ERR_ABRT   2
`define DPS_ERR_IDNF   4
`define DPS_ERR_WF     5
`define DPS_ERR_CRC    6

// parameter reset defaults
`define DPS_RST_E      1'b1
`define DPS_RST_H      1'b0
`define DPS_RST_S      1'b0
`define DPS_RST_D      1'b0
`define DPS_RST_K      1'b0

// byte values
`define DPS_ALT_FILL   8'hff
`define DPS_SYNC_NAT   8'ha1
`define DPS_SYNC_DEF   8'hfe

// field lengths and byte-time counts
`define DPS_ID_LEN     12'h005
`define DPS_GATE_FIX   12'h005
`define DPS_CL_LEN     12'h001
`define DPS_ECC4       12'h004
`define DPS_ECC7       12'h007
`define DPS_CRC_LEN    12'h002
`define DPS_SZ_BASE    12'h080

// crc presets and polynomial
`define DPS_CRC_ONES   16'hffff
`define DPS_CRC_ZERO   16'h0000
`define DPS_CRC_POLY   16'h1021

// span and coding encodings
`define DPS_SPAN_5     2'h0
`define DPS_SPAN_11    2'h1
`define DPS_SPAN_22    2'h2
`define DPS_CODE_RLL   2'h0
`define DPS_CODE_MFM   2'h1
`define DPS_CODE_NRZ   2'h2

`endif

// [rtl/dps_crc16.v]
// byte-wide crc-16 generator and checker for dumped fields
// assumes init and upd are never high in the same cycle
`timescale 1ns/1ps
`include "dps_defs.vh"

module dps_crc16 (
	input  wire        clk,
	input  wire        rstn,
	input  wire        init,
	input  wire [15:0] preset,
	input  wire        upd,
	input  wire [7:0]  din,
	output wire [15:0] crc
);
	reg [15:0] crc_q;

	// one byte of the polynomial division, msb first
	function [15:0] crc_byte;
		input [15:0] c;
		input [7:0]  d;
		integer      i;
		reg [15:0]   r;
		begin
			r = c ^ {d, 8'h00};
			for (i = 0; i < 8; i = i + 1) begin
				r = r[15] ? ({r[14:0], 1'b0} ^ `DPS_CRC_POLY) : {r[14:0], 1'b0};
			end
			crc_byte = r;
		end
	endfunction

	// preset on init, fold in bytes on upd
	always @(posedge clk) begin
		if (!rstn) begin
			crc_q <= `DPS_CRC_ZERO;
		end else if (init) begin
			crc_q <= preset;
		end else if (upd) begin
			crc_q <= crc_byte(crc_q, din);
		end
	end

	assign crc = crc_q;
endmodule // dps_crc16

// [rtl/dps_cmd.v]
// set parameter, load parameter block, sleep and dump command logic
// assumes an avalon-mm master, a buffer manager that takes every byte strobe,
// and a data separator that delivers one disk byte per disk_byte_valid pulse
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "dps_defs.vh"

module dps_cmd (
	input  wire        clk,
	input  wire        rstn,
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire        drive_ready,
	input  wire        write_fault,
	input  wire        index_pulse,
	input  wire        sector_pulse,
	input  wire [7:0]  disk_byte,
	input  wire        disk_byte_valid,
	input  wire        buffer_ready,
	output wire        buffer_request,
	output wire        micro_request_irq,
	output wire [7:0]  buf_wr_data,
	output wire        buf_wr_valid,
	output wire        micro_interrupt,
	output wire        read_gate,
	output wire        disk_clk_enable,
	output wire        ecc_len7,
	output wire        head_bits4,
	output wire [1:0]  span_sel,
	output wire [1:0]  code_mode,
	output wire        reloc_en,
	output wire        hard_sector,
	output wire [10:0] sector_size,
	output wire [7:0]  gap_len,
	output wire [7:0]  gap_fill,
	output wire [7:0]  pad_fill
);
	// one-hot command states
	localparam [8:0] S_IDLE = 9'h001;
	localparam [8:0] S_EXEC = 9'h002;
	localparam [8:0] S_BREQ = 9'h004;
	localparam [8:0] S_WIDX = 9'h008;
	localparam [8:0] S_GATE = 9'h010;
	localparam [8:0] S_SYNC = 9'h020;
	localparam [8:0] S_FLD  = 9'h040;
	localparam [8:0] S_CHK  = 9'h080;
	localparam [8:0] S_WSEC = 9'h100;

	// bus and task file
	reg        wait_q;
	reg [31:0] rdata_q;
	reg [7:0]  plo_q, scnt_q, snum_q, szlo_q, szhi_q, dh_q, cmd_q, err_q, alt_q;
	reg        reqen_q;
	// latched parameters
	reg        e_q, h_q, s_q, z_q, r_q, d_q, k_q, u_q;
	reg [10:0] usz_q;
	reg [7:0]  gap_q, gfill_q, pfill_q;
	// derived parameter outputs
	reg        ecc7_q;
	reg [1:0]  span_q, code_q;
	reg [10:0] ssz_q;
	// command engine
	reg [8:0]  st_q;
	reg        done_q, sleep_q, breq_q, dirq_q, rg_q, idph_q;
	reg [11:0] cnt_q, tgt_q;
	reg [7:0]  bdat_q;
	reg        bval_q;
	reg        crc_init_q;
	reg [7:0]  rd_mux;
	reg        done_set;
	reg        sleep_set;

	wire        wr       = avs_write & ~wait_q & avs_byteenable[0];
	wire [5:0]  ix       = avs_address[7:2];
	wire [7:0]  wd       = avs_writedata[7:0];
	wire        task_wr  = wr & ~sleep_q & (st_q == S_IDLE);
	wire [2:0]  op       = cmd_q[7:5];
	wire        opt_i    = cmd_q[`DPS_DM_I];
	wire        opt_b    = cmd_q[`DPS_DM_B];
	wire        opt_l    = cmd_q[`DPS_DM_L];
	wire [15:0] crc;

	// sector size from user register or drive/head code
	function [10:0] size_of;
		input        u;
		input [10:0] usz;
		input [1:0]  code;
		reg   [11:0] t;
		begin
			t = `DPS_SZ_BASE << code;
			size_of = u ? usz : t[10:0];
		end
	endfunction

	// sync byte for the chosen format
	wire [7:0]  sync_b   = opt_b ? `DPS_SYNC_NAT : `DPS_SYNC_DEF;
	wire [11:0] ecc_n    = ecc7_q ? `DPS_ECC7 : `DPS_ECC4;
	// bytes stored and total bytes of the current field
	wire [11:0] data_len = {1'b0, ssz_q} + {11'h000, opt_b};
	wire [11:0] one_len  = {1'b0, ssz_q} + 12'h001;
	wire [11:0] fld_len  = idph_q ? `DPS_ID_LEN : (opt_i ? one_len : data_len);
	wire [11:0] tot_len  = fld_len + (opt_l ? ecc_n : `DPS_CRC_LEN);
	wire        store    = opt_l | (cnt_q < fld_len);
	wire [7:0]  scnt_dec = scnt_q - 8'h01;

	dps_crc16 u_crc (
		.clk    (clk),
		.rstn   (rstn),
		.init   (crc_init_q),
		.preset (opt_b ? `DPS_CRC_ONES : `DPS_CRC_ZERO),
		.upd    ((st_q == S_FLD) & disk_byte_valid),
		.din    (disk_byte),
		.crc    (crc)
	);

	// read data multiplexer, unmapped indices read zero
	always @* begin
		rd_mux = 8'h00;
		case (ix)
			`DPS_IX_GATE:  rd_mux = err_q;
			`DPS_IX_SCNT:  rd_mux = scnt_q;
			`DPS_IX_SNUM:  rd_mux = snum_q;
			`DPS_IX_SZLO:  rd_mux = szlo_q;
			`DPS_IX_SZHI:  rd_mux = szhi_q;
			`DPS_IX_DH:    rd_mux = dh_q;
			`DPS_IX_CMD:   rd_mux = {st_q != S_IDLE, drive_ready, write_fault, sleep_q,
				3'h0, err_q != 8'h00};
			`DPS_IX_ISTAT: rd_mux = {4'h0, done_q, 3'h0};
			`DPS_IX_PARAM: rd_mux = {r_q, z_q, s_q, h_q, e_q, u_q, k_q, d_q};
			`DPS_IX_CTRL:  rd_mux = {7'h00, reqen_q};
			`DPS_IX_ALT:   rd_mux = alt_q;
			default:       rd_mux = 8'h00;
		endcase
	end

	// bus handshake: waitrequest drops in the second cycle of each request
	always @(posedge clk) begin
		if (!rstn) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= ~((avs_read | avs_write) & wait_q);
			if (avs_read & wait_q) begin
				rdata_q <= {24'h000000, rd_mux};
			end
		end
	end

	// derived parameter outputs
	always @(posedge clk) begin
		if (!rstn) begin
			ecc7_q <= 1'b1;
			span_q <= `DPS_SPAN_11;
			code_q <= `DPS_CODE_RLL;
			ssz_q  <= 11'h000;
		end else begin
			ecc7_q <= e_q | ~k_q;
			if (e_q | ~k_q) begin
				span_q <= s_q ? `DPS_SPAN_22 : `DPS_SPAN_11;
			end else begin
				span_q <= s_q ? `DPS_SPAN_11 : `DPS_SPAN_5;
			end
			code_q <= ~k_q ? `DPS_CODE_RLL : (z_q ? `DPS_CODE_NRZ : `DPS_CODE_MFM);
			ssz_q  <= size_of(u_q, usz_q, dh_q[6:5]);
		end
	end

	// done flag and sleep state; a hardware set beats a software clear
	always @(posedge clk) begin
		if (!rstn) begin
			done_q  <= 1'b0;
			sleep_q <= 1'b0;
			reqen_q <= 1'b0;
		end else begin
			if (done_set) begin
				done_q <= 1'b1;
			end else if (wr & (ix == `DPS_IX_ISTAT) & wd[`DPS_ISTAT_DONE]) begin
				done_q <= 1'b0;
			end
			if (sleep_set) begin
				sleep_q <= 1'b1;
			end else if (wr & (ix == `DPS_IX_CTRL) & wd[`DPS_CTRL_WAKE]) begin
				sleep_q <= 1'b0;
			end
			if (wr & (ix == `DPS_IX_CTRL)) begin
				reqen_q <= wd[`DPS_CTRL_REQEN];
			end
		end
	end

	// completion and sleep requests decoded from the engine state
	always @* begin
		done_set  = 1'b0;
		sleep_set = 1'b0;
		case (st_q)
			S_EXEC: begin
				done_set  = ~drive_ready | write_fault | (op != `DPS_OP_DUMP);
				sleep_set = drive_ready & ~write_fault & (op == `DPS_OP_SLEEP);
			end
			S_SYNC: begin
				done_set = index_pulse;
			end
			S_CHK: begin
				done_set = ~idph_q & ((scnt_dec == 8'h00) | ~d_q);
				if (!opt_l & (crc != `DPS_CRC_ZERO)) begin
					done_set = 1'b1;
				end
			end
			default: ;
		endcase
	end

	// command engine and task file
	always @(posedge clk) begin
		if (!rstn) begin
			st_q  <= S_IDLE;
			plo_q <= 8'h00;
			scnt_q <= 8'h00;
			snum_q <= 8'h00;
			szlo_q <= 8'h00;
			szhi_q <= 8'h00;
			dh_q  <= 8'h00;
			cmd_q <= 8'h00;
			err_q <= 8'h00;
			alt_q <= 8'h00;
			e_q   <= `DPS_RST_E;
			h_q   <= `DPS_RST_H;
			s_q   <= `DPS_RST_S;
			z_q   <= 1'b0;
			r_q   <= 1'b0;
			d_q   <= `DPS_RST_D;
			k_q   <= `DPS_RST_K;
			u_q   <= 1'b0;
			usz_q <= 11'h000;
			gap_q <= 8'h00;
			gfill_q <= 8'h00;
			pfill_q <= 8'h00;
			breq_q <= 1'b0;
			dirq_q <= 1'b0;
			rg_q  <= 1'b0;
			idph_q <= 1'b0;
			cnt_q <= 12'h000;
			tgt_q <= 12'h000;
			bdat_q <= 8'h00;
			bval_q <= 1'b0;
			crc_init_q <= 1'b0;
		end else begin
			bval_q     <= 1'b0;
			crc_init_q <= 1'b0;
			// task file writes only while idle and awake
			if (task_wr) begin
				case (ix)
					`DPS_IX_GATE: plo_q  <= wd;
					`DPS_IX_SCNT: scnt_q <= wd;
					`DPS_IX_SNUM: snum_q <= wd;
					`DPS_IX_SZLO: szlo_q <= wd;
					`DPS_IX_SZHI: szhi_q <= wd;
					`DPS_IX_DH:   dh_q   <= wd;
					`DPS_IX_CMD: begin
						cmd_q <= wd;
						err_q <= 8'h00;
						st_q  <= S_EXEC;
					end
					default: ;
				endcase
			end
			if (wr & (ix == `DPS_IX_ALT) & (st_q == S_IDLE)) begin
				alt_q <= wd;
			end
			case (st_q)
				S_IDLE: ;
				S_EXEC: begin
					alt_q <= `DPS_ALT_FILL;
					if (!drive_ready | write_fault) begin
						err_q[`DPS_ERR_ABRT] <= 1'b1;
						err_q[`DPS_ERR_NRDY] <= ~drive_ready;
						err_q[`DPS_ERR_WF]   <= write_fault;
						st_q <= S_IDLE;
					end else begin
						case (op)
							`DPS_OP_SETP: begin
								e_q <= cmd_q[`DPS_SP_E];
								h_q <= cmd_q[`DPS_SP_H];
								s_q <= cmd_q[`DPS_SP_S];
								z_q <= cmd_q[`DPS_SP_Z];
								r_q <= cmd_q[`DPS_SP_R];
								st_q <= S_IDLE;
							end
							`DPS_OP_LPB: begin
								d_q <= cmd_q[`DPS_LP_D];
								k_q <= cmd_q[`DPS_LP_K];
								u_q <= cmd_q[`DPS_LP_U];
								usz_q <= {szhi_q[2:0], szlo_q};
								gap_q <= plo_q;
								gfill_q <= scnt_q;
								pfill_q <= snum_q;
								st_q <= S_IDLE;
							end
							`DPS_OP_SLEEP: begin
								st_q <= S_IDLE;
							end
							`DPS_OP_DUMP: begin
								if (reqen_q) begin
									breq_q <= 1'b1;
									dirq_q <= 1'b1;
									st_q   <= S_BREQ;
								end else begin
									st_q <= S_WIDX;
								end
							end
							default: begin
								err_q[`DPS_ERR_ABRT] <= 1'b1;
								st_q <= S_IDLE;
							end
						endcase
					end
				end
				S_BREQ: begin
					if (buffer_ready) begin
						breq_q <= 1'b0;
						dirq_q <= 1'b0;
						st_q   <= S_WIDX;
					end
				end
				S_WIDX: begin
					if (index_pulse) begin
						cnt_q  <= 12'h000;
						tgt_q  <= {4'h0, plo_q} + `DPS_GATE_FIX + `DPS_CL_LEN;
						idph_q <= ~opt_i;
						st_q   <= S_GATE;
					end
				end
				S_GATE: begin
					if (cnt_q >= tgt_q) begin
						rg_q <= 1'b1;
						st_q <= S_SYNC;
					end else if (disk_byte_valid) begin
						cnt_q <= cnt_q + 12'h001;
					end
				end
				S_SYNC: begin
					if (index_pulse) begin
						// index passed while still searching
						if (idph_q) begin
							err_q[`DPS_ERR_IDNF] <= 1'b1;
						end else begin
							err_q[`DPS_ERR_DAM] <= 1'b1;
						end
						rg_q <= 1'b0;
						st_q <= S_IDLE;
					end else if (disk_byte_valid & (disk_byte == sync_b)) begin
						crc_init_q <= 1'b1;
						cnt_q <= 12'h000;
						st_q  <= S_FLD;
					end
				end
				S_FLD: begin
					if (disk_byte_valid) begin
						if (store) begin
							bdat_q <= disk_byte;
							bval_q <= 1'b1;
						end
						cnt_q <= cnt_q + 12'h001;
						if (cnt_q == tot_len - 12'h001) begin
							st_q <= S_CHK;
						end
					end
				end
				S_CHK: begin
					if (!opt_l & (crc != `DPS_CRC_ZERO)) begin
						if (idph_q) begin
							err_q[`DPS_ERR_IDNF] <= 1'b1;
						end else begin
							err_q[`DPS_ERR_CRC] <= 1'b1;
						end
						rg_q <= 1'b0;
						st_q <= S_IDLE;
					end else if (idph_q) begin
						idph_q <= 1'b0;
						st_q   <= S_SYNC;
					end else begin
						scnt_q <= scnt_dec;
						rg_q   <= 1'b0;
						if ((scnt_dec == 8'h00) | ~d_q) begin
							st_q <= S_IDLE;
						end else begin
							st_q <= S_WSEC;
						end
					end
				end
				S_WSEC: begin
					if (sector_pulse) begin
						cnt_q  <= 12'h000;
						tgt_q  <= {4'h0, gap_q};
						idph_q <= ~opt_i;
						st_q   <= S_GATE;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// outputs straight from flops, except disk_clk_enable, which is sleep_q inverted
	assign avs_readdata      = rdata_q;
	assign avs_waitrequest   = wait_q;
	assign buffer_request    = breq_q;
	assign micro_request_irq = dirq_q;
	assign buf_wr_data       = bdat_q;
	assign buf_wr_valid      = bval_q;
	assign micro_interrupt   = done_q;
	assign read_gate         = rg_q;
	assign disk_clk_enable   = ~sleep_q ? 1'b1 : 1'b0;
	assign ecc_len7          = ecc7_q;
	assign head_bits4        = h_q;
	assign span_sel          = span_q;
	assign code_mode         = code_q;
	assign reloc_en          = r_q;
	assign hard_sector       = d_q;
	assign sector_size       = ssz_q;
	assign gap_len           = gap_q;
	assign gap_fill          = gfill_q;
	assign pad_fill          = pfill_q;
endmodule // dps_cmd

// [tb/dps_cmd_properties.sv]
// port assertions for the command block
// assumes binding onto dps_cmd, one clock, synchronous active-low reset
`timescale 1ns/1ps
module dps_cmd_properties (
	input wire        clk,
	input wire        rstn,
	input wire [7:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0]  avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	input wire        drive_ready,
	input wire        write_fault,
	input wire [7:0]  disk_byte,
	input wire        disk_byte_valid,
	input wire        buffer_ready,
	input wire        buffer_request,
	input wire        micro_request_irq,
	input wire [7:0]  buf_wr_data,
	input wire        buf_wr_valid,
	input wire        micro_interrupt,
	input wire        read_gate,
	input wire        disk_clk_enable,
	input wire        head_bits4,
	input wire        reloc_en,
	input wire        hard_sector,
	input wire [7:0]  gap_len
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// accepted register writes
	wire [5:0] ix = avs_address[7:2];
	wire       acc = avs_write && !avs_waitrequest && avs_byteenable[0];
	wire       cmd = acc && ix == 6'h27 && disk_clk_enable;
	reg  [2:0] sp_q;
	reg  [2:0] lp_q;
	// short windows after parameter commands
	always @(posedge clk) begin
		if (!rstn) begin
			sp_q <= 3'h0;
			lp_q <= 3'h0;
		end else begin
			sp_q <= (cmd && avs_writedata[7:5] == 3'h0) ? 3'h4 : sp_q - (sp_q != 3'h0);
			lp_q <= (cmd && avs_writedata[7:5] == 3'h1) ? 3'h4 : lp_q - (lp_q != 3'h0);
		end
	end
	sequence s_short;
		cmd && avs_writedata[7:5] < 3'h3;
	endsequence
	sequence s_sleep;
		cmd && avs_writedata[7:5] == 3'h2 && drive_ready && !write_fault;
	endsequence
	sequence s_wake;
		acc && ix == 6'h3b && avs_writedata[7];
	endsequence
	chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer after one wait");
	chk_read_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_done_time: assert property (s_short |-> ##2 micro_interrupt)
		else $error("done not raised two cycles after command");
	chk_sleep_stop: assert property (s_sleep |-> ##[1:3] !disk_clk_enable)
		else $error("sleep did not stop disk clocks");
	chk_wake_run: assert property (s_wake |-> ##[1:3] disk_clk_enable)
		else $error("wake did not restart disk clocks");
	chk_req_hold: assert property (buffer_request && !buffer_ready |=> buffer_request)
		else $error("buffer request dropped before ready");
	chk_req_pair: assert property (micro_request_irq == buffer_request)
		else $error("request and micro request differ");
	chk_store_source: assert property (buf_wr_valid |->
		$past(disk_byte_valid) && $past(read_gate) && buf_wr_data == $past(disk_byte))
		else $error("stored byte not from gated disk byte");
	chk_setp_hold: assert property ($changed(head_bits4) || $changed(reloc_en) |-> sp_q != 3'h0)
		else $error("set parameter bits changed without command");
	chk_lpb_hold: assert property ($changed(hard_sector) || $changed(gap_len) |-> lp_q != 3'h0)
		else $error("load block values changed without command");
endmodule // dps_cmd_properties

bind dps_cmd dps_cmd_properties dps_cmd_properties_inst (.*);

// [tb/dps_disk_model.sv]
// buffer manager and drive model for dump traffic
// assumes the bench fills trk and trk_len before issuing a dump
`timescale 1ns/1ps
module dps_disk_model (
	input  wire        clk,
	input  wire        buffer_request,
	output logic       buffer_ready,
	output logic       index_pulse,
	output logic [7:0] disk_byte,
	output logic       disk_byte_valid
);
	logic [7:0] trk [0:63];
	int         trk_len;
	// answer the request slowly, then spin one track from index
	initial begin
		buffer_ready = 1'b0;
		index_pulse = 1'b0;
		disk_byte = 8'h00;
		disk_byte_valid = 1'b0;
		forever begin
			@(posedge clk);
			if (buffer_request === 1'b1) begin
				repeat ($urandom_range(4, 1)) @(posedge clk);
				buffer_ready <= 1'b1;
				do @(posedge clk); while (buffer_request === 1'b1);
				buffer_ready <= 1'b0;
				index_pulse <= 1'b1;
				@(posedge clk);
				index_pulse <= 1'b0;
				for (int i = 0; i < trk_len; i++) begin
					repeat (2) @(posedge clk);
					disk_byte <= trk[i];
					disk_byte_valid <= 1'b1;
					@(posedge clk);
					disk_byte <= ~trk[i]; // no stale byte between strobes
					disk_byte_valid <= 1'b0;
				end
			end
		end
	end
endmodule // dps_disk_model

// [tb/dps_cmd_bench.sv]
// self-checking bench for the parameter, sleep and dump commands
// assumes dps_cmd at 200 MHz with the disk model as far side
`timescale 1ns/1ps
module dps_cmd_bench;
	logic        clk, rstn, avs_read, avs_write, drive_ready, write_fault;
	logic        sector_pulse, index_pulse, disk_byte_valid, buffer_ready;
	logic [7:0]  avs_address, disk_byte, q, b, m;
	logic [31:0] avs_writedata, o;
	logic [3:0]  avs_byteenable;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest, buffer_request, micro_request_irq, buf_wr_valid;
	wire         micro_interrupt, read_gate, disk_clk_enable, ecc_len7, head_bits4;
	wire         reloc_en, hard_sector;
	wire  [7:0]  buf_wr_data, gap_len, gap_fill, pad_fill;
	wire  [1:0]  span_sel, code_mode;
	wire  [10:0] sector_size;
	logic [47:0] v;
	logic [4:0]  sp;
	logic [2:0]  lp;
	logic [15:0] c;
	logic        hprev, gate_q, breq_q;
	logic [7:0]  got [$];
	logic [7:0]  exq [$];
	int          errors, num_checks, bcnt, gate_at, nreq, n, g, len;

	dps_cmd dps_cmd_inst (.*);
	dps_disk_model dps_disk_model_inst (.*);

	// clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic void chk(input logic [31:0] got_v, input logic [31:0] exp_v, input string s);
		num_checks++;
		if (got_v !== exp_v) begin
			errors++;
			$display("[FAIL] %0t %s", $time, s);
		end
	endfunction

	function automatic logic [15:0] crc_upd(input logic [15:0] cc, input logic [7:0] d);
		cc = cc ^ {d, 8'h00};
		for (int i = 0; i < 8; i++) cc = cc[15] ? (cc << 1) ^ 16'h1021 : cc << 1;
		return cc;
	endfunction

	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [5:0] ix, input logic [7:0] d);
		avs_address <= {ix, 2'b00};
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic cmd(input logic [7:0] op);
		bus(1'b1, 6'h27, op);
		while (micro_interrupt !== 1'b1) @(posedge clk);
		bus(1'b1, 6'h38, 8'h08);
		chk(micro_interrupt, 1'b0, "done not cleared");
		bus(1'b0, 6'h3c, 8'h00);
		chk(q, 8'hff, "alternate sector");
	endtask

	task automatic end_of_test();
		if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// stored bytes, byte times since index, request count
	always @(posedge clk) begin
		if (buf_wr_valid === 1'b1) got.push_back(buf_wr_data);
		if (index_pulse) bcnt <= 0;
		else if (disk_byte_valid) bcnt <= bcnt + 1;
		if (read_gate === 1'b1 && !gate_q) gate_at <= bcnt;
		if (buffer_request === 1'b1 && !breq_q) nreq <= nreq + 1;
		gate_q <= read_gate;
		breq_q <= buffer_request;
	end

	// watchdog
	initial begin
		#200000;
		errors++;
		end_of_test();
	end

	// main sequence
	initial begin
		{rstn, avs_read, avs_write, write_fault, sector_pulse} = 5'h0;
		{avs_address, avs_writedata, hprev, gate_q, breq_q} = '0;
		{bcnt, gate_at, nreq, errors, num_checks} = '0;
		drive_ready = 1'b1;
		avs_byteenable = 4'h1;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		void'($urandom(32'hf46585c5));
		repeat (2) @(posedge clk);
		chk(ecc_len7, 1'b1, "ecc default");
		chk(head_bits4, 1'b0, "head default");
		chk(span_sel, 2'h1, "span default");
		chk(code_mode, 2'h0, "coding default");
		chk(hard_sector, 1'b0, "sector mode default");
		chk(sector_size, 11'h080, "size default");
		bus(1'b0, 6'h10, 8'h00);
		chk(q, 8'h00, "unmapped read");
		for (int i = 0; i < 10; i++) begin
			o = $urandom;
			v = {$urandom, $urandom};
			sp = o[4:0];
			lp = {o[4] | o[7], o[6:5]};
			for (int k = 0; k < 6; k++) bus(1'b1, 6'h21 + k, v[8*k +: 8]);
			cmd({5'h04, lp});
			chk(head_bits4, hprev, "head bits kept");
			chk(hard_sector, lp[0], "sector mode");
			chk(gap_fill, v[15:8], "gap fill");
			chk(pad_fill, v[23:16], "pad fill");
			chk(sector_size, lp[2] ? {v[34:32], v[31:24]} : 11'h080 << v[46:45], "size");
			cmd({3'h0, sp});
			chk(gap_len, v[7:0], "gap length");
			chk(head_bits4, sp[1], "head bits");
			chk(reloc_en, sp[4], "relocation");
			chk(code_mode, lp[1] ? {sp[3], !sp[3]} : 2'h0, "coding");
			if (lp[1]) chk({ecc_len7, span_sel}, {sp[0], sp[0] & sp[2], sp[0] ^ sp[2]}, "ecc");
			hprev = sp[1];
		end
		for (int k = 0; k < 2; k++) begin
			drive_ready <= k[0];
			write_fault <= k[0];
			m = k ? 8'h24 : 8'h06;
			cmd({3'h0, ~sp});
			bus(1'b0, 6'h21, 8'h00);
			chk(q & m, m, "abort flags");
			chk(head_bits4, sp[1], "aborted command kept bits");
		end
		drive_ready <= 1'b1;
		write_fault <= 1'b0;
		cmd(8'h40);
		chk(disk_clk_enable, 1'b0, "sleep");
		bus(1'b1, 6'h3b, 8'h81);
		repeat (3) @(posedge clk);
		chk(disk_clk_enable, 1'b1, "wake");
		for (int p = 0; p < 3; p++) begin
			n = 2 + $urandom_range(6);
			g = $urandom_range(7);
			bus(1'b1, 6'h21, g[7:0]);
			bus(1'b1, 6'h22, 8'h01);
			bus(1'b1, 6'h24, n[7:0]);
			bus(1'b1, 6'h25, 8'h00);
			cmd(8'h26);
			len = 0;
			repeat (g + 6) dps_disk_model_inst.trk[len++] = 8'h4e;
			dps_disk_model_inst.trk[len++] = 8'h00;
			dps_disk_model_inst.trk[len++] = p[0] ? 8'ha1 : 8'hfe;
			c = p[0] ? 16'hffff : 16'h0000;
			exq.delete();
			for (int j = 0; j <= n; j++) begin
				b = $urandom;
				exq.push_back(b);
				c = crc_upd(c, b);
				dps_disk_model_inst.trk[len++] = b;
			end
			if (p == 2) c = c ^ 16'h0001;
			dps_disk_model_inst.trk[len++] = c[15:8];
			dps_disk_model_inst.trk[len++] = c[7:0];
			dps_disk_model_inst.trk_len = len;
			got.delete();
			nreq = 0;
			cmd({3'h5, 3'h0, p[0], 1'b1});
			chk(got.size(), n + 1, "stored count");
			for (int j = 0; j < got.size() && j <= n; j++) chk(got[j], exq[j], "stored byte");
			chk(gate_at, g + 6, "first read gate");
			chk(nreq, 1, "one buffer request");
			bus(1'b0, 6'h21, 8'h00);
			chk(q & 8'h40, p == 2 ? 8'h40 : 8'h00, "data crc flag");
			bus(1'b0, 6'h22, 8'h00);
			chk(q, p == 2 ? 8'h01 : 8'h00, "sector count");
		end
		end_of_test();
	end
endmodule // dps_cmd_bench
